// File: hdl/mivc_map.svh
`ifndef MIVC_MAP_SVH
`define MIVC_MAP_SVH
`define MIVC_NSRC          13
`define MIVC_VEC_EXT0      16'h0003
`define MIVC_VEC_TMR0      16'h000b
`define MIVC_VEC_EXT1      16'h0013
`define MIVC_VEC_TMR1      16'h001b
`define MIVC_VEC_SER0      16'h0023
`define MIVC_VEC_SER1      16'h003b
`define MIVC_VEC_PHY       16'h0043
`define MIVC_VEC_TMR2      16'h004b
`define MIVC_VEC_CIPH      16'h0053
`define MIVC_VEC_TMR3      16'h005b
`define MIVC_VEC_SLEEP     16'h0063
`define MIVC_VEC_SPI       16'h0068
`define MIVC_VEC_VOICE     16'h0073
`define MIVC_GIE_BIT       7
`define MIVC_BIE_RST       8'h00
`define MIVC_SER_PEND_BIT  0
`define MIVC_SER_CAUSE_HI  3
`define MIVC_SER_CAUSE_LO  1
`endif

// File: hdl/mivc_pkg.sv
`default_nettype none
package mivc_pkg;
  typedef enum logic [1:0] {
    MIVC_IDLE,
    MIVC_IN_LOW,
    MIVC_IN_HIGH,
    MIVC_IN_HIGH_OVER_LOW
  } mivc_level_t;
  typedef logic [15:0] mivc_addr_t;
  typedef logic [3:0]  mivc_ord_t;
endpackage : mivc_pkg
`default_nettype wire

// File: hdl/mivc_sel_if.sv
`default_nettype none
interface mivc_sel_if;
  logic [12:0]          req;
  logic                 found;
  logic [3:0]           idx;
  modport picker (input req, output found, output idx);
  modport user   (output req, input found, input idx);
endinterface : mivc_sel_if
`default_nettype wire

// File: hdl/mivc_pick.sv
`default_nettype none
// Lowest-index active request wins; index equals table position, so ordinal order is kept.
module mivc_pick (
  mivc_sel_if.picker s
);
  always_comb begin
    s.found = 1'b0;
    s.idx   = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (s.req[i]) begin
        s.found = 1'b1;
        s.idx   = 4'(i);
      end
    end
  end
endmodule : mivc_pick
`default_nettype wire

// File: hdl/mivc_voice.sv
`default_nettype none
module mivc_voice (
  input  wire logic [23:0] en_i,
  input  wire logic [23:0] flag_i,
  output logic             req_o
);
  assign req_o = |(en_i & flag_i);
endmodule : mivc_voice
`default_nettype wire

// File: hdl/mivc_top.sv
`include "mivc_map.svh"
`default_nettype none
module mivc_top (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Pending flags from peripherals and pins, with the voice enable mask.
  input  wire logic        ext0_flag_i,
  input  wire logic        tmr0_flag_i,
  input  wire logic        ext1_flag_i,
  input  wire logic        tmr1_flag_i,
  input  wire logic [3:0]  ser0_ident_i,
  input  wire logic [3:0]  ser1_ident_i,
  input  wire logic        radio_phy_irq_flag_i,
  input  wire logic        tmr2_flag_i,
  input  wire logic        cipher_flag_i,
  input  wire logic        tmr3_flag_i,
  input  wire logic        sleep_timer_irq_flag_i,
  input  wire logic        spi_done_flag_i,
  input  wire logic [23:0] voice_irq_enable_i,
  input  wire logic [23:0] voice_irq_flag_i,
  // Enable and priority settings.
  input  wire logic [7:0]  base_irq_enable_reg_i,
  input  wire logic [7:0]  base_irq_priority_reg_i,
  input  wire logic [7:0]  extended_irq_enable_reg_i,
  input  wire logic [7:0]  extended_irq_priority_reg_i,
  input  wire logic        spi_local_irq_enable_i,
  // Core handshake.
  input  wire logic        ack_i,
  input  wire logic        reti_i,
  output logic             irq_o,
  output logic [15:0]      vector_o,
  output logic [3:0]       ordinal_o,
  output logic             level_o,
  output logic [2:0]       ser0_cause_o,
  output logic [2:0]       ser1_cause_o,
  output logic [1:0]       active_o
);

  logic                 ext0_s1_r, ext0_s2_r, ext1_s1_r, ext1_s2_r;
  logic [12:0]          pend, en, prio, ok;
  logic                 voice_req;
  logic                 in_low, in_high;
  logic                 take_hi, take_lo;
  mivc_pkg::mivc_level_t state_r, state_nxt;
  mivc_pkg::mivc_ord_t   ord_tbl [13];
  mivc_pkg::mivc_addr_t  vec_tbl [13];
  mivc_sel_if            sel_hi ();
  mivc_sel_if            sel_lo ();

  // Pins are synchronised before use.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext0_s1_r <= 1'b0;
      ext0_s2_r <= 1'b0;
      ext1_s1_r <= 1'b0;
      ext1_s2_r <= 1'b0;
    end else begin
      ext0_s1_r <= ext0_flag_i;
      ext0_s2_r <= ext0_s1_r;
      ext1_s1_r <= ext1_flag_i;
      ext1_s2_r <= ext1_s1_r;
    end
  end

  mivc_voice u_voice (
    .en_i   (voice_irq_enable_i),
    .flag_i (voice_irq_flag_i),
    .req_o  (voice_req)
  );

  // Table position k serves ordinal ord_tbl[k]; positions ascend by ordinal.
  assign ord_tbl = '{4'd0, 4'd1, 4'd2, 4'd3, 4'd4, 4'd7, 4'd8, 4'd9,
                     4'd10, 4'd11, 4'd12, 4'd13, 4'd14};
  assign vec_tbl = '{`MIVC_VEC_EXT0, `MIVC_VEC_TMR0, `MIVC_VEC_EXT1, `MIVC_VEC_TMR1,
                     `MIVC_VEC_SER0, `MIVC_VEC_SER1,
                     `MIVC_VEC_PHY, `MIVC_VEC_TMR2, `MIVC_VEC_CIPH, `MIVC_VEC_TMR3,
                     `MIVC_VEC_SLEEP, `MIVC_VEC_SPI, `MIVC_VEC_VOICE};

  // Pending flags; pins and internal events feed the same path.
  assign pend = {voice_req, spi_done_flag_i, sleep_timer_irq_flag_i, tmr3_flag_i,
                 cipher_flag_i, tmr2_flag_i, radio_phy_irq_flag_i,
                 ser1_ident_i[`MIVC_SER_PEND_BIT], ser0_ident_i[`MIVC_SER_PEND_BIT],
                 tmr1_flag_i, ext1_s2_r, tmr0_flag_i, ext0_s2_r};

  assign en = {extended_irq_enable_reg_i[6],
               extended_irq_enable_reg_i[5] & spi_local_irq_enable_i,
               extended_irq_enable_reg_i[4:0],
               base_irq_enable_reg_i[6], base_irq_enable_reg_i[4:0]};

  assign prio = {extended_irq_priority_reg_i[6:0],
                 base_irq_priority_reg_i[6], base_irq_priority_reg_i[4:0]};

  assign ok = pend & en & {13{base_irq_enable_reg_i[`MIVC_GIE_BIT]}};

  assign sel_hi.req = ok & prio;
  assign sel_lo.req = ok & ~prio;

  mivc_pick u_pick_hi (.s (sel_hi));
  mivc_pick u_pick_lo (.s (sel_lo));

  assign in_high = (state_r == mivc_pkg::MIVC_IN_HIGH) || (state_r == mivc_pkg::MIVC_IN_HIGH_OVER_LOW);
  assign in_low  = (state_r == mivc_pkg::MIVC_IN_LOW);
  assign take_hi = sel_hi.found && !in_high;
  assign take_lo = sel_lo.found && !sel_hi.found && (state_r == mivc_pkg::MIVC_IDLE);

  // Nesting state tracks which handler levels are in progress.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mivc_pkg::MIVC_IDLE: begin
        if (ack_i && irq_o) begin
          state_nxt = level_o ? mivc_pkg::MIVC_IN_HIGH : mivc_pkg::MIVC_IN_LOW;
        end
      end
      mivc_pkg::MIVC_IN_LOW: begin
        if (ack_i && irq_o) begin
          state_nxt = mivc_pkg::MIVC_IN_HIGH_OVER_LOW;
        end else if (reti_i) begin
          state_nxt = mivc_pkg::MIVC_IDLE;
        end
      end
      mivc_pkg::MIVC_IN_HIGH: begin
        if (reti_i) begin
          state_nxt = mivc_pkg::MIVC_IDLE;
        end
      end
      mivc_pkg::MIVC_IN_HIGH_OVER_LOW: begin
        if (reti_i) begin
          state_nxt = mivc_pkg::MIVC_IN_LOW;
        end
      end
      default: state_nxt = mivc_pkg::MIVC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= mivc_pkg::MIVC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Request presented to the core; refreshed every cycle, dropped once acknowledged.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o     <= 1'b0;
      vector_o  <= 16'h0000;
      ordinal_o <= 4'h0;
      level_o   <= 1'b0;
    end else if (ack_i && irq_o) begin
      irq_o <= 1'b0;
    end else if (take_hi) begin
      irq_o     <= 1'b1;
      vector_o  <= vec_tbl[sel_hi.idx];
      ordinal_o <= ord_tbl[sel_hi.idx];
      level_o   <= 1'b1;
    end else if (take_lo) begin
      irq_o     <= 1'b1;
      vector_o  <= vec_tbl[sel_lo.idx];
      ordinal_o <= ord_tbl[sel_lo.idx];
      level_o   <= 1'b0;
    end else begin
      irq_o <= 1'b0;
    end
  end

  // Serial cause codes passed through for the handler.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser0_cause_o <= 3'h0;
      ser1_cause_o <= 3'h0;
    end else begin
      ser0_cause_o <= ser0_ident_i[`MIVC_SER_CAUSE_HI:`MIVC_SER_CAUSE_LO];
      ser1_cause_o <= ser1_ident_i[`MIVC_SER_CAUSE_HI:`MIVC_SER_CAUSE_LO];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_o <= 2'b00;
    end else begin
      active_o <= {in_high, in_low | (state_r == mivc_pkg::MIVC_IN_HIGH_OVER_LOW)};
    end
  end

endmodule : mivc_top
`default_nettype wire

// File: tb/mivc_core_model.sv
`default_nettype none
module mivc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       irq_i,
  input  wire logic       ret_req_i,
  input  wire logic [1:0] lat_i,
  output logic            ack_o,
  output logic            reti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  // Takes a raised request after lat_i cycles; returns only when the bench asks.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o  <= 1'b0;
      reti_o <= 1'b0;
      wait_r <= 2'h0;
    end else begin
      ack_o  <= 1'b0;
      reti_o <= ret_req_i;
      wait_r <= 2'h0;
      if (irq_i && !ack_o && wait_r == lat_i) ack_o <= 1'b1;
      else if (irq_i && !ack_o) wait_r <= wait_r + 2'h1;
    end
  end
endmodule : mivc_core_model
`default_nettype wire

// File: tb/mivc_top_assertions.sv
`default_nettype none
module mivc_top_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        ack_i,
  input wire logic        reti_i,
  input wire logic        irq_o,
  input wire logic [15:0] vector_o,
  input wire logic [3:0]  ordinal_o,
  input wire logic        level_o,
  input wire logic [1:0]  active_o,
  input wire logic [7:0]  base_irq_enable_reg_i,
  input wire logic        tmr0_flag_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    irq_o && ack_i;
  endsequence
  sequence s_low_run;
    active_o == 2'b01;
  endsequence
  // The activity output trails the nesting state by one cycle, so its checks look two edges ahead.
  a_take_drops_irq: assert property (s_take |=> !irq_o && $stable(vector_o)) else $error("no drop");
  a_take_marks_run: assert property (s_take ##0 active_o == 2'b00 ##1 1'b1 |=>
    active_o == {$past(level_o), !$past(level_o)}) else $error("bad active");
  a_global_off: assert property (!base_irq_enable_reg_i[7] |=> !irq_o) else $error("gie");
  a_high_blocks: assert property (active_o[1] |-> !irq_o) else $error("irq in high");
  a_low_only_high: assert property (s_low_run ##0 irq_o |-> level_o) else $error("low nest");
  a_vec_ext0: assert property (irq_o && ordinal_o == 4'h0 |-> vector_o == 16'h0003) else $error("v0");
  a_vec_tmr0: assert property (irq_o && ordinal_o == 4'h1 |-> vector_o == 16'h000b) else $error("v1");
  a_vec_spi: assert property (irq_o && ordinal_o == 4'hd |-> vector_o == 16'h0068) else $error("v13");
  a_reti_pops: assert property (reti_i && !ack_i ##0 s_low_run |=> ##1 active_o == 2'b00)
    else $error("pop");
  a_tmr0_rises: assert property (tmr0_flag_i && base_irq_enable_reg_i[7] && base_irq_enable_reg_i[1] &&
    active_o == 2'b00 && !irq_o && !$past(irq_o && ack_i) |=> irq_o && (ordinal_o <= 4'h1 || level_o))
    else $error("late");
endmodule : mivc_top_assertions
bind mivc_top mivc_top_assertions u_mivc_top_assertions (.clk_i, .rstn_i, .ack_i, .reti_i, .irq_o,
  .vector_o, .ordinal_o, .level_o, .active_o, .base_irq_enable_reg_i, .tmr0_flag_i);
`default_nettype wire

// File: tb/test_mivc_top.sv
`default_nettype none
module test_mivc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] vec_tab [13] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h003b,
    16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h0068, 16'h0073};
  localparam logic [3:0] ord_tab [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
    4'hd, 4'he};
  logic        clk_i = 1'b0, rstn_i = 1'b0, spi_le = 1'b1, ret_req = 1'b0;
  logic [12:0] pend = 13'h0;
  logic [7:0]  ben = 8'hdf, xpr = 8'h00;
  logic [23:0] ven = 24'hffffff;
  logic [1:0]  lat = 2'h0, act;
  logic        ack, reti, irq, lvl;
  logic [15:0] vec;
  logic [3:0]  ord;
  logic [2:0]  cs0, cs1;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  mivc_top u_mivc_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .ext0_flag_i(pend[0]), .tmr0_flag_i(pend[1]), .ext1_flag_i(pend[2]),
    .tmr1_flag_i(pend[3]), .ser0_ident_i({3'h5, pend[4]}), .ser1_ident_i({3'h6, pend[5]}),
    .radio_phy_irq_flag_i(pend[6]), .tmr2_flag_i(pend[7]), .cipher_flag_i(pend[8]), .tmr3_flag_i(pend[9]),
    .sleep_timer_irq_flag_i(pend[10]), .spi_done_flag_i(pend[11]), .voice_irq_enable_i(ven),
    .voice_irq_flag_i({23'h0, pend[12]}), .base_irq_enable_reg_i(ben), .base_irq_priority_reg_i(8'h00),
    .extended_irq_enable_reg_i(8'h7f), .extended_irq_priority_reg_i(xpr), .spi_local_irq_enable_i(spi_le),
    .ack_i(ack), .reti_i(reti), .irq_o(irq), .vector_o(vec), .ordinal_o(ord), .level_o(lvl),
    .ser0_cause_o(cs0), .ser1_cause_o(cs1), .active_o(act));
  mivc_core_model u_mivc_core_model (.clk_i(clk_i), .rstn_i(rstn_i), .irq_i(irq), .ret_req_i(ret_req),
    .lat_i(lat), .ack_o(ack), .reti_o(reti));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_irq(logic [15:0] v, logic [3:0] o, logic l, logic [1:0] a);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    chk("vector", vec, v);
    chk("ordinal", {12'h0, ord}, {12'h0, o});
    chk("level", {15'h0, lvl}, {15'h0, l});
    repeat (5) @(negedge clk_i);
    chk("active", {14'h0, act}, {14'h0, a});
  endtask : wait_irq
  task automatic ret(logic [1:0] a);
    repeat (2) @(negedge clk_i);
    ret_req = 1'b1;
    @(negedge clk_i);
    ret_req = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("active", {14'h0, act}, {14'h0, a});
  endtask : ret
  task automatic quiet;
    repeat (6) begin
      @(negedge clk_i);
      chk("irq", {15'h0, irq}, 16'h0000);
    end
  endtask : quiet
  task automatic t_vec;
    for (int i = 0; i < 13; i++) begin
      pend = 13'h1 << i;
      wait_irq(vec_tab[i], ord_tab[i], 1'b0, 2'b01);
      if (i == 4) chk("cause0", {13'h0, cs0}, 16'h0005);
      if (i == 5) chk("cause1", {13'h0, cs1}, 16'h0006);
      pend = 13'h0;
      ret(2'b00);
    end
  endtask : t_vec
  task automatic t_order;
    pend = 13'h088;
    wait_irq(16'h001b, 4'h3, 1'b0, 2'b01);
    pend = 13'h080;
    ret(2'b00);
    wait_irq(16'h004b, 4'h9, 1'b0, 2'b01);
    pend = 13'h0;
    ret(2'b00);
  endtask : t_order
  task automatic t_nest;
    lat = 2'h2;
    xpr = 8'h02;
    pend = 13'h001;
    wait_irq(16'h0003, 4'h0, 1'b0, 2'b01);
    pend = 13'h080;
    wait_irq(16'h004b, 4'h9, 1'b1, 2'b11);
    pend = 13'h008;
    quiet;
    ret(2'b01);
    quiet;
    ret(2'b00);
    wait_irq(16'h001b, 4'h3, 1'b0, 2'b01);
    pend = 13'h0;
    ret(2'b00);
    lat = 2'h0;
    xpr = 8'h00;
  endtask : t_nest
  task automatic t_gate;
    ben = 8'h5f;
    pend = 13'h002;
    quiet;
    ben = 8'hdf;
    wait_irq(16'h000b, 4'h1, 1'b0, 2'b01);
    pend = 13'h0;
    ret(2'b00);
    spi_le = 1'b0;
    pend = 13'h800;
    quiet;
    spi_le = 1'b1;
    ven = 24'hfffffe;
    pend = 13'h1000;
    quiet;
    pend = 13'h0;
    ven = 24'hffffff;
  endtask : t_gate
  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(negedge clk_i);
    rstn_i = 1'b1;
    @(negedge clk_i);
    t_vec;
    t_order;
    t_nest;
    t_gate;
    report_and_stop;
  end
endmodule : test_mivc_top
`default_nettype wire
